// *** rtl/lrwfp_pkg.sv ***
/*
  Shared constants for the low-rate wireless frame path: frame layout,
  timing counts, buffer sizes and the state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lrwfp_pkg;
  // Frame layout
  localparam int          PREAMBLE_BYTES   = 4;
  localparam logic [7:0]  PREAMBLE_BYTE    = 8'h00;
  localparam logic [7:0]  SFD_BYTE         = 8'hA7;
  localparam logic [6:0]  MAX_PAYLOAD      = 7'h7D;
  localparam logic [15:0] CRC_POLY_REFL    = 16'h8408;
  localparam logic [15:0] CRC_INIT         = 16'h0000;
  localparam logic [6:0]  RESET_LENGTH     = 7'h00;
  localparam logic [7:0]  RESET_LQI        = 8'h00;
  // Timing
  localparam int          CLK_MHZ          = 125;
  localparam int          LQI_WINDOW_US    = 64;
  localparam int          LQI_CYCLES       = LQI_WINDOW_US * CLK_MHZ;
  localparam int          CCA_WINDOW_US    = 128;
  localparam int          CCA_CYCLES       = CCA_WINDOW_US * CLK_MHZ;
  // Buffer
  localparam int          BUF_DEPTH        = 128;
  // Main sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_TX_PRE  = 4'b0001,
    ST_TX_SFD  = 4'b0010,
    ST_TX_LEN  = 4'b0011,
    ST_TX_PAY  = 4'b0100,
    ST_TX_FCS  = 4'b0101,
    ST_RX_HUNT = 4'b0110,
    ST_RX_LEN  = 4'b0111,
    ST_RX_PAY  = 4'b1000,
    ST_RX_FCS  = 4'b1001,
    ST_CCA     = 4'b1010
  } lrwfp_state_type;
endpackage

// *** rtl/lrwfp_frame_path.sv ***
/*
  Frame path of a low-rate 2.4 GHz modem: builds transmit frames
  (preamble, delimiter, length, payload, check sequence), parses received
  frames, checks the sequence, measures link quality, runs channel checks.
  Assumes the byte link clock (link_clk_i) and link data come from outside
  and are synchronised here; host side signals are on clk_i.
*/
// Overview of operation
// - Buffered mode keeps whole packet in RAM
// - Streaming mode passes words one at a time
// - Payload up to 125 bytes accepted
// - Prepend four preamble, delimiter, length bytes
// - Append check sequence after payload
// - Hunt for delimiter, parse length on receive; preamble not checked
// - Buffered receive stores payload and sequence
// - Compare computed sequence, report pass/fail
// - Link quality over 64 us after delimiter
// - Buffered receive: one interrupt per packet
// - Streaming receive: interrupt per word
// - Channel check integrates energy over window
// - Buffered transmit: load, start, done interrupt
// - Streaming transmit: interrupt per accepted word
`timescale 1ns/10ps
module lrwfp_frame_path import lrwfp_pkg::*; #(
  parameter int          LQI_CYC    = LQI_CYCLES,
  parameter int          CCA_CYC    = CCA_CYCLES,
  parameter logic [7:0]  CCA_THRESH = 8'h40
) (
  input  wire logic       clk_i,          // Core clock
  input  wire logic       rst_n_i,        // Async reset, active low
  input  wire logic       buffered_i,     // 1 buffered, 0 streaming
  input  wire logic       tx_start_i,     // Start transmit pulse
  input  wire logic [6:0] tx_length_i,    // Payload length
  input  wire logic       host_wr_i,      // Host writes a byte
  input  wire logic [6:0] host_addr_i,    // Buffer address
  input  wire logic [7:0] host_wdata_i,   // Host write data
  input  wire logic       rx_enable_i,    // Receive enable level
  input  wire logic       cca_start_i,    // Channel check request
  input  wire logic [7:0] energy_i,       // Baseband energy sample
  input  wire logic       link_clk_i,     // Link byte clock, async
  input  wire logic [7:0] link_rx_i,      // Received link byte
  output logic [7:0]      host_rdata_o,   // Buffer read data
  output logic [7:0]      rx_word_o,      // Streamed received byte
  output logic [6:0]      rx_length_o,    // Received payload length
  output logic            crc_ok_o,       // Check result
  output logic [7:0]      lqi_o,          // Link quality
  output logic            cca_busy_o,     // Channel found busy
  output logic            cca_done_o,     // Channel check done pulse
  output logic            irq_o,          // Host interrupt pulse
  output logic [7:0]      link_tx_o,      // Transmitted byte
  output logic            link_tx_valid_o // Transmit byte valid
);
  // Window counters are 16 bits wide
  if (LQI_CYC < 1 || CCA_CYC < 1 || LQI_CYC > 65536 || CCA_CYC > 65536)
    $error("Window counts must lie between 1 and 65536 cycles");

  // Whole state of the block
  typedef struct packed {
    lrwfp_state_type st;
    logic [2:0]  lk_sync;   // Link clock synchroniser and edge history
    logic [7:0]  rx_s1;     // Link data first stage
    logic [7:0]  rx_s2;     // Link data second stage
    logic [6:0]  count;     // Byte counter
    logic [6:0]  length;    // Payload length
    logic [15:0] crc;       // Running check value
    logic [15:0] fcs_rx;    // Received check sequence
    logic [7:0]  host_rd;   // Host read data
    logic [7:0]  rx_word;   // Streamed byte
    logic [6:0]  rx_len;    // Reported length
    logic        crc_ok;    // Latched result
    logic [7:0]  lqi;       // Link quality result
    logic [15:0] win;       // Window counter
    logic [23:0] acc;       // Energy accumulator
    logic        cca_busy;  // Channel result
    logic        cca_done;  // Channel done pulse
    logic        irq;       // Interrupt pulse
    logic        lqi_run;   // Quality window active
    logic [7:0]  tx_byte;   // Outgoing byte
    logic        tx_valid;  // Outgoing byte valid
    logic [7:0]  s_word;    // Streamed transmit word
  } lrwfp_regs_type;

  lrwfp_regs_type r;       // Registered state
  lrwfp_regs_type next_r;  // Next state

  logic [7:0] buf_mem [BUF_DEPTH];
  logic       mem_we;       // Receive-side write strobe
  logic [6:0] mem_waddr;    // Receive-side write address
  logic [7:0] mem_wdata;    // Receive-side write data
  logic       lk_edge;      // Rising link clock edge
  logic [7:0] rx_byte;      // Synchronised received byte

  // CRC16 byte update, reflected ITU-T form
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      v = v[0] ? ((v >> 1) ^ CRC_POLY_REFL) : (v >> 1);
    return v;
  endfunction

  assign lk_edge = r.lk_sync[1] & ~r.lk_sync[2];
  assign rx_byte = r.rx_s2;

  // Buffer write: host writes unless receive writes, receive writes win on collision
  always_ff @(posedge clk_i) begin
    if (mem_we)
      buf_mem[mem_waddr] <= mem_wdata;
    else if (host_wr_i)
      buf_mem[host_addr_i] <= host_wdata_i;
  end

  // Next-state logic
  always_comb begin
    next_r           = r;
    mem_we           = 1'b0;
    mem_waddr        = r.count;
    mem_wdata        = rx_byte;
    next_r.lk_sync   = {r.lk_sync[1:0], link_clk_i};
    next_r.rx_s1     = link_rx_i;
    next_r.rx_s2     = r.rx_s1;
    next_r.irq       = 1'b0;
    next_r.cca_done  = 1'b0;
    next_r.host_rd   = buf_mem[host_addr_i];
    if (!buffered_i && host_wr_i)
      next_r.s_word = host_wdata_i;
    if (r.lqi_run) begin
      next_r.win = r.win + 16'h0001;
      next_r.acc = r.acc + {16'h0000, energy_i};
      if (r.win == 16'(LQI_CYC - 1)) begin
        next_r.lqi_run = 1'b0;
        next_r.lqi     = 8'((r.acc + {16'h0000, energy_i}) / LQI_CYC);
      end
    end
    case (r.st)
      ST_IDLE: begin
        next_r.tx_valid = 1'b0;
        if (tx_start_i && tx_length_i <= MAX_PAYLOAD) begin
          next_r.st     = ST_TX_PRE;
          next_r.count  = 7'h00;
          next_r.length = tx_length_i;
          next_r.crc    = CRC_INIT;
        // Window counter is shared, so no check while quality runs
        end else if (cca_start_i && !r.lqi_run) begin
          next_r.st  = ST_CCA;
          next_r.win = 16'h0000;
          next_r.acc = 24'h000000;
        end else if (rx_enable_i) begin
          next_r.st = ST_RX_HUNT;
        end
      end
      ST_TX_PRE: if (lk_edge) begin
        next_r.tx_byte  = PREAMBLE_BYTE;
        next_r.tx_valid = 1'b1;
        next_r.count    = r.count + 7'h01;
        if (r.count == 7'(PREAMBLE_BYTES - 1))
          next_r.st = ST_TX_SFD;
      end
      ST_TX_SFD: if (lk_edge) begin
        next_r.tx_byte = SFD_BYTE;
        next_r.st      = ST_TX_LEN;
      end
      // length field includes two check bytes
      ST_TX_LEN: if (lk_edge) begin
        next_r.tx_byte = {1'b0, r.length + 7'h02};
        next_r.count   = 7'h00;
        next_r.st      = (r.length == 7'h00) ? ST_TX_FCS : ST_TX_PAY;
        if (!buffered_i && r.length != 7'h00)
          next_r.irq = 1'b1;
      end
      ST_TX_PAY: if (lk_edge) begin
        // source from buffer or streamed word
        next_r.tx_byte = buffered_i ? buf_mem[r.count] : r.s_word;
        next_r.crc     = crc_step(r.crc,
                           buffered_i ? buf_mem[r.count] : r.s_word);
        next_r.count   = r.count + 7'h01;
        if (r.count + 7'h01 == r.length) begin
          next_r.st    = ST_TX_FCS;
          next_r.count = 7'h00;
        end else if (!buffered_i) begin
          next_r.irq = 1'b1;
        end
      end
      // append check sequence, low byte first
      ST_TX_FCS: if (lk_edge) begin
        next_r.tx_byte = (r.count == 7'h00) ? r.crc[7:0] : r.crc[15:8];
        next_r.count   = r.count + 7'h01;
        if (r.count == 7'h01) begin
          next_r.st  = ST_IDLE;
          next_r.irq = 1'b1;
        end
      end
      ST_RX_HUNT: begin
        if (!rx_enable_i)
          next_r.st = ST_IDLE;
        else if (lk_edge && rx_byte == SFD_BYTE) begin
          next_r.st      = ST_RX_LEN;
          next_r.lqi_run = 1'b1;
          next_r.win     = 16'h0000;
          next_r.acc     = 24'h000000;
          next_r.crc_ok  = 1'b0;
        end
      end
      ST_RX_LEN: if (lk_edge) begin
        if (rx_byte < 8'h02 || rx_byte > {1'b0, MAX_PAYLOAD} + 8'h02)
          next_r.st = ST_RX_HUNT;
        else begin
          next_r.length = 7'(rx_byte - 8'h02);
          next_r.rx_len = 7'(rx_byte - 8'h02);
          next_r.count  = 7'h00;
          next_r.crc    = CRC_INIT;
          next_r.st     = (rx_byte == 8'h02) ? ST_RX_FCS : ST_RX_PAY;
        end
      end
      ST_RX_PAY: if (lk_edge) begin
        mem_we         = buffered_i;
        next_r.crc     = crc_step(r.crc, rx_byte);
        next_r.rx_word = rx_byte;
        next_r.irq     = !buffered_i;
        next_r.count   = r.count + 7'h01;
        if (r.count + 7'h01 == r.length)
          next_r.st = ST_RX_FCS;
      end
      ST_RX_FCS: if (lk_edge) begin
        mem_we       = buffered_i;
        next_r.count = r.count + 7'h01;
        if (r.count == r.length)
          next_r.fcs_rx[7:0] = rx_byte;
        else begin
          next_r.fcs_rx[15:8] = rx_byte;
          next_r.crc_ok = (r.crc == {rx_byte, r.fcs_rx[7:0]});
          next_r.st     = ST_IDLE;
          if (buffered_i)
            next_r.irq = 1'b1;
        end
      end
      ST_CCA: begin
        next_r.win = r.win + 16'h0001;
        next_r.acc = r.acc + {16'h0000, energy_i};
        if (r.win == 16'(CCA_CYC - 1)) begin
          next_r.cca_busy = 8'((r.acc + {16'h0000, energy_i}) / CCA_CYC)
                            >= CCA_THRESH;
          next_r.cca_done = 1'b1;
          next_r.st       = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.length <= RESET_LENGTH;
      r.rx_len <= RESET_LENGTH;
      r.lqi    <= RESET_LQI;
      r.crc    <= CRC_INIT;
    end else begin
      r <= next_r;
    end
  end

  assign host_rdata_o    = r.host_rd;
  assign rx_word_o       = r.rx_word;
  assign rx_length_o     = r.rx_len;
  assign crc_ok_o        = r.crc_ok;
  assign lqi_o           = r.lqi;
  assign cca_busy_o      = r.cca_busy;
  assign cca_done_o      = r.cca_done;
  assign irq_o           = r.irq;
  assign link_tx_o       = r.tx_byte;
  assign link_tx_valid_o = r.tx_valid;
endmodule // lrwfp_frame_path

// *** verif/lrwfp_link_partner.sv ***
/*
  Link side model: sends one byte per link clock period of 64 ns.
  Assumes the bench calls send_byte; the clock stands still between calls.
*/
`timescale 1ns/10ps
module lrwfp_link_partner (
  output logic       link_clk_o, // Byte clock, low when idle
  output logic [7:0] link_rx_o   // Byte towards the frame path
);
  // Idle levels
  initial begin
    link_clk_o = 1'b0;
    link_rx_o  = 8'h00;
  end
  task automatic send_byte(input logic [7:0] b);
    link_rx_o = b;
    // Rising edge lands between core clock edges
    #30;
    link_clk_o = 1'b1;
    #34;
    link_clk_o = 1'b0;
    // Hold time over: stale value is not left on the line
    link_rx_o = ~b;
  endtask
endmodule // lrwfp_link_partner

// *** verif/lrwfp_frame_path_checker.sv ***
/*
  Port checker for the frame path.
  Assumes it is bound into lrwfp_frame_path with its CCA_CYC.
*/
`timescale 1ns/10ps
module lrwfp_frame_path_checker import lrwfp_pkg::*; #(
  parameter int CCA_CYC = CCA_CYCLES
) (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       tx_start_i,
  input wire logic [6:0] tx_length_i,
  input wire logic       host_wr_i,
  input wire logic [6:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic       cca_start_i,
  input wire logic       link_clk_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic [6:0] rx_length_o,
  input wire logic       cca_done_o,
  input wire logic       irq_o,
  input wire logic [7:0] link_tx_o,
  input wire logic       link_tx_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  int   since_cca;  // Cycles since the last channel check request
  int   since_link; // Cycles since the link clock last moved
  logic link_q;     // Link clock level one cycle ago
  // Helper counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_cca  <= 0;
      since_link <= 0;
      link_q     <= 1'b0;
    end else begin
      since_cca  <= cca_start_i ? 0 : since_cca + 1;
      since_link <= (link_clk_i != link_q) ? 0 : since_link + 1;
      link_q     <= link_clk_i;
    end
  end
  property p_irq_pulse;
    irq_o |=> !irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  property p_done_pulse;
    cca_done_o |=> !cca_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("check done longer than one cycle");
  property p_cca_window;
    cca_done_o |-> since_cca >= CCA_CYC - 1 && since_cca <= CCA_CYC + 8;
  endproperty
  a_cca_window: assert property (p_cca_window)
    else $error("channel check window length wrong");
  property p_first_byte;
    $rose(link_tx_valid_o) |-> link_tx_o == PREAMBLE_BYTE;
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("frame does not open with preamble");
  property p_tx_on_edge;
    $changed(link_tx_o) && link_tx_valid_o |-> since_link <= 6;
  endproperty
  a_tx_on_edge: assert property (p_tx_on_edge)
    else $error("transmit byte changed without link edge");
  property p_long_refused;
    tx_start_i && tx_length_i > MAX_PAYLOAD && !link_tx_valid_o
      |=> !link_tx_valid_o [*8];
  endproperty
  a_long_refused: assert property (p_long_refused)
    else $error("over-long transmit started");
  property p_rx_len_max;
    rx_length_o <= MAX_PAYLOAD;
  endproperty
  a_rx_len_max: assert property (p_rx_len_max)
    else $error("received length above limit");
  property p_read_back;
    host_wr_i ##1 host_addr_i == $past(host_addr_i)
      |=> host_rdata_o == $past(host_wdata_i, 2);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("buffer read differs from write");
endmodule // lrwfp_frame_path_checker
bind lrwfp_frame_path lrwfp_frame_path_checker #(.CCA_CYC(CCA_CYC)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_start_i(tx_start_i),
  .tx_length_i(tx_length_i), .host_wr_i(host_wr_i),
  .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
  .cca_start_i(cca_start_i), .link_clk_i(link_clk_i),
  .host_rdata_o(host_rdata_o), .rx_length_o(rx_length_o),
  .cca_done_o(cca_done_o), .irq_o(irq_o), .link_tx_o(link_tx_o),
  .link_tx_valid_o(link_tx_valid_o));

// *** verif/lrwfp_frame_path_bench.sv ***
/*
  Self-checking bench: transmit, refused length, receive in both modes,
  channel check. Assumes the link partner model and the checker bind.
*/
`timescale 1ns/10ps
module lrwfp_frame_path_bench import lrwfp_pkg::*; ;
  logic       clk_i, rst_n_i, buffered_i, tx_start_i, host_wr_i;
  logic       rx_enable_i, cca_start_i, crc_ok_o, cca_busy_o, cca_done_o;
  logic       irq_o, link_tx_valid_o, link_clk_w;
  logic [6:0] tx_length_i, host_addr_i, rx_length_o;
  logic [7:0] host_wdata_i, energy_i, link_rx_w, host_rdata_o, rx_word_o;
  logic [7:0] lqi_o, link_tx_o;
  logic [7:0] pay [0:124]; // Payload pattern
  int         err_count, tests_run, irq_cnt, cyc;
  lrwfp_link_partner link_u (.link_clk_o(link_clk_w), .link_rx_o(link_rx_w));
  lrwfp_frame_path #(.LQI_CYC(16), .CCA_CYC(16)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .buffered_i(buffered_i),
    .tx_start_i(tx_start_i), .tx_length_i(tx_length_i),
    .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .rx_enable_i(rx_enable_i),
    .cca_start_i(cca_start_i), .energy_i(energy_i),
    .link_clk_i(link_clk_w), .link_rx_i(link_rx_w),
    .host_rdata_o(host_rdata_o), .rx_word_o(rx_word_o),
    .rx_length_o(rx_length_o), .crc_ok_o(crc_ok_o), .lqi_o(lqi_o),
    .cca_busy_o(cca_busy_o), .cca_done_o(cca_done_o), .irq_o(irq_o),
    .link_tx_o(link_tx_o), .link_tx_valid_o(link_tx_valid_o));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Interrupt counter and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (irq_o === 1'b1) irq_cnt++;
    if (cyc == 10000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Reflected check sequence over the first n payload bytes
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, pay[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] tx_exp(input int i, n);
    logic [15:0] c;
    c = crc_of(n);
    if (i < 4) return PREAMBLE_BYTE;
    if (i == 4) return SFD_BYTE;
    if (i == 5) return 8'(n + 2);
    if (i < n + 6) return pay[i - 6];
    return (i == n + 6) ? c[7:0] : c[15:8];
  endfunction
  task automatic start_tx(input int n);
    @(posedge clk_i);
    tx_start_i  <= 1'b1;
    tx_length_i <= 7'(n);
    @(posedge clk_i);
    tx_start_i  <= 1'b0;
  endtask
  task automatic tx_test(input logic mode, input int n);
    int irq0;
    @(posedge clk_i);
    buffered_i <= mode;
    for (int i = 0; mode && i < n; i++) begin
      @(posedge clk_i);
      host_wr_i    <= 1'b1;
      host_addr_i  <= 7'(i);
      host_wdata_i <= pay[i];
      @(posedge clk_i);
      host_wr_i    <= 1'b0;
    end
    irq0 = irq_cnt;
    start_tx(n);
    for (int i = 0; i < n + 8; i++) begin
      link_u.send_byte(8'h00);
      repeat (3) @(negedge clk_i);
      check("tx byte", {8'h00, tx_exp(i, n)}, {8'h00, link_tx_o});
      check("tx valid", {15'h0, i < n + 7}, {15'h0, link_tx_valid_o});
      if (!mode && i >= 5 && i < n + 5) begin
        @(posedge clk_i);
        host_wr_i    <= 1'b1;
        host_wdata_i <= pay[i - 5];
        @(posedge clk_i);
        host_wr_i    <= 1'b0;
      end
    end
    check("tx irq", 16'(mode ? 1 : n + 1), 16'(irq_cnt - irq0));
    $display("tx test done");
  endtask
  task automatic refuse_test;
    start_tx(126);
    repeat (2) link_u.send_byte(8'h00);
    repeat (10) @(negedge clk_i);
    check("refused valid", 16'h0000, {15'h0, link_tx_valid_o});
    // Over-long received length field goes back to hunting
    @(posedge clk_i);
    rx_enable_i <= 1'b1;
    link_u.send_byte(SFD_BYTE);
    link_u.send_byte(8'h80);
    link_u.send_byte(8'h01);
    @(posedge clk_i);
    rx_enable_i <= 1'b0;
    @(negedge clk_i);
    check("rx long length", {9'h0, RESET_LENGTH}, {9'h0, rx_length_o});
    $display("refuse test done");
  endtask
  task automatic rx_test(input logic mode, bad, input int n);
    logic [15:0] c;
    int          irq0;
    c    = crc_of(n);
    irq0 = irq_cnt;
    @(posedge clk_i);
    buffered_i  <= mode;
    rx_enable_i <= 1'b1;
    energy_i    <= 8'h33;
    for (int i = 0; i < 4; i++) link_u.send_byte(PREAMBLE_BYTE);
    link_u.send_byte(SFD_BYTE);
    link_u.send_byte(8'(n + 2));
    for (int i = 0; i < n; i++) link_u.send_byte(pay[i]);
    link_u.send_byte(c[7:0] ^ {7'h00, bad});
    link_u.send_byte(c[15:8]);
    repeat (10) @(posedge clk_i);
    rx_enable_i <= 1'b0;
    @(negedge clk_i);
    check("crc ok", {15'h0, ~bad}, {15'h0, crc_ok_o});
    check("rx length", 16'(n), {9'h0, rx_length_o});
    check("lqi", 16'h0033, {8'h00, lqi_o});
    check("rx word", {8'h00, pay[n - 1]}, {8'h00, rx_word_o});
    check("rx irq", 16'(mode ? 1 : n), 16'(irq_cnt - irq0));
    for (int i = 0; mode && i < n + 2; i++) begin
      @(posedge clk_i);
      host_addr_i <= 7'(i);
      repeat (2) @(negedge clk_i);
      check("rx store", {8'h00, i < n ? pay[i] : (i == n ? c[7:0] : c[15:8])},
            {8'h00, host_rdata_o});
    end
    $display("rx test done");
  endtask
  task automatic cca_test(input logic [7:0] e);
    int w;
    @(posedge clk_i);
    energy_i    <= e;
    cca_start_i <= 1'b1;
    @(posedge clk_i);
    cca_start_i <= 1'b0;
    for (w = 0; w < 100 && cca_done_o !== 1'b1; w++) @(negedge clk_i);
    check("cca done", 16'h0001, {15'h0, cca_done_o});
    check("cca busy", {15'h0, e >= 8'h40}, {15'h0, cca_busy_o});
    $display("cca test done");
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, tx_start_i, host_wr_i, rx_enable_i, cca_start_i} = 5'h00;
    {tx_length_i, host_addr_i, host_wdata_i, energy_i} = 30'h0;
    buffered_i = 1'b1;
    for (int i = 0; i < 125; i++) pay[i] = 8'(i * 37 + 5);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tx_test(1'b1, 125);
    tx_test(1'b0, 5);
    refuse_test();
    rx_test(1'b1, 1'b0, 5);
    rx_test(1'b0, 1'b1, 5);
    cca_test(8'h50);
    cca_test(8'h10);
    complete_run();
  end
endmodule // lrwfp_frame_path_bench
